/* File: verification/adel_viol_src.sv */
// Purpose: far-side model, axi masters hitting undecoded space
// Assumes: tasks are called from the bench main sequence
// Notes:   attr packs burst,len,size,prot; stale fields inverted
`timescale 1ns/1ps
module adel_viol_src (
  input  wire logic    clk_sys,
  output logic         rdValid,
  output logic [11:0]  rdAttr,
  output logic [7:0]   rdId,
  output logic [63:0]  rdAddr,
  output logic         wrValid,
  output logic [11:0]  wrAttr,
  output logic [7:0]   wrId,
  output logic [63:0]  wrAddr,
  output logic [127:0] wrData
);
  // idle, nothing in flight
  initial begin
    rdValid = 1'b0;
    wrValid = 1'b0;
    {rdAttr, rdId, rdAddr} = '0;
    {wrAttr, wrId, wrAddr, wrData} = '0;
  end
  // one read violation pulse, released after the last of a run
  task automatic rdViol(input logic [11:0] a, input logic [7:0] i,
                        input logic [63:0] d, input bit last);
    @(negedge clk_sys);
    rdValid = 1'b1;
    {rdAttr, rdId, rdAddr} = {a, i, d};
    @(posedge clk_sys);
    if (last) begin
      @(negedge clk_sys);
      rdValid = 1'b0;
      {rdAttr, rdId, rdAddr} = ~{a, i, d}; // no stale value left
    end
  endtask
  // one write violation pulse with its data beat
  task automatic wrViol(input logic [11:0] a, input logic [7:0] i,
                        input logic [63:0] d, input logic [127:0] w, input bit last);
    @(negedge clk_sys);
    wrValid = 1'b1;
    {wrAttr, wrId, wrAddr, wrData} = {a, i, d, w};
    @(posedge clk_sys);
    if (last) begin
      @(negedge clk_sys);
      wrValid = 1'b0;
      {wrAttr, wrId, wrAddr, wrData} = ~{a, i, d, w}; // no stale value left
    end
  endtask
endmodule

/* File: verification/axi_decode_error_logger_bench.sv */
// Purpose: self-checking bench of the decode error logger
// Assumes: inputs change on the falling clock edge
// Notes:   log depth cut to 2 so overflow comes quickly
`timescale 1ns/1ps
module axi_decode_error_logger_bench;
  localparam int          DEPTH = 2;
  localparam logic [11:0] RA    = {2'h2, 4'hf, 3'h7, 3'h5}; // read attributes
  localparam logic [11:0] WA    = {2'h1, 4'h3, 3'h2, 3'h6}; // write attributes
  typedef struct packed {
    logic [8:0]  ofs;
    logic [31:0] expv;
  } adel_row_t;
  logic         clk_sys, sys_rst, csrEnable, read, write;
  logic [8:0]   address;
  logic [31:0]  writedata, readdata;
  logic         readdatavalid, rdRespValid, wrRespValid, irqRead, irqWrite;
  logic [1:0]   rdResp, wrResp;
  logic         rdValid, wrValid;
  logic [11:0]  rdAttr, wrAttr;
  logic [7:0]   rdId, wrId;
  logic [63:0]  rdAddr, wrAddr;
  logic [127:0] wrData;
  int           error_cnt, tests_run;
  adel_row_t    rows [16];

  adel_viol_src i_adel_viol_src (.clk_sys(clk_sys), .rdValid(rdValid), .rdAttr(rdAttr),
    .rdId(rdId), .rdAddr(rdAddr), .wrValid(wrValid), .wrAttr(wrAttr), .wrId(wrId),
    .wrAddr(wrAddr), .wrData(wrData));
  adel_logger #(.ID_W(8), .ADDR_W(64), .DATA_W(128), .DEPTH(DEPTH)) i_adel_logger (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .csrEnable(csrEnable), .rdViolValid(rdValid),
    .rdViolBurst(rdAttr[11:10]), .rdViolLen(rdAttr[9:6]), .rdViolSize(rdAttr[5:3]),
    .rdViolProt(rdAttr[2:0]), .rdViolId(rdId), .rdViolAddr(rdAddr), .wrViolValid(wrValid),
    .wrViolBurst(wrAttr[11:10]), .wrViolLen(wrAttr[9:6]), .wrViolSize(wrAttr[5:3]),
    .wrViolProt(wrAttr[2:0]), .wrViolId(wrId), .wrViolAddr(wrAddr), .wrViolData(wrData),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .readdatavalid(readdatavalid), .rdRespValid(rdRespValid),
    .rdResp(rdResp), .wrRespValid(wrRespValid), .wrResp(wrResp), .irqRead(irqRead),
    .irqWrite(irqWrite));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    tests_run++;
    if (got !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  // csr read, answer checked one cycle later; strobe left up
  task automatic csrRd(input logic [8:0] a, input logic [31:0] e);
    write = 1'b0;
    read = 1'b1;
    address = a;
    @(negedge clk_sys);
    chk({31'h0000_0000, readdatavalid}, 32'h0000_0001);
    chk(readdata, e);
  endtask
  // csr write of one cycle
  task automatic csrWr(input logic [8:0] a, input logic [31:0] d);
    read = 1'b0;
    write = 1'b1;
    address = a;
    writedata = d;
    @(negedge clk_sys);
  endtask
  // drop both strobes
  task automatic csrIdle();
    read = 1'b0;
    write = 1'b0;
  endtask
  // verdict and end of run
  task automatic results();
    $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // hang guard, far beyond the roughly 70 cycles needed
  initial begin
    repeat (3000) @(posedge clk_sys);
    error_cnt++;
    results();
  end
  // main sequence
  initial begin
    sys_rst = 1'b1;
    csrEnable = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 9'h000;
    writedata = 32'h0000_0000;
    error_cnt = 0;
    tests_run = 0;
    rows = '{
      '{adel_pkg::OFS_STATUS,     32'h0000_0003},
      '{adel_pkg::OFS_RD_ATTR,    {19'h0_0000, RA, 1'b1}},
      '{adel_pkg::OFS_RD_ID,      32'h0000_00a5},
      '{adel_pkg::OFS_RD_ADDR_LO, 32'h9abc_def0},
      '{adel_pkg::OFS_RD_ATTR,    32'h0000_0000},
      '{adel_pkg::OFS_WR_ATTR,    {19'h0_0000, WA, 1'b1}},
      '{adel_pkg::OFS_WR_ID,      32'h0000_005a},
      '{adel_pkg::OFS_WR_ADDR_LO, 32'h7654_3210},
      '{adel_pkg::OFS_WR_ADDR_HI, 32'hfedc_ba98},
      '{adel_pkg::OFS_WR_DATA0,   32'haaaa_0000},
      '{adel_pkg::OFS_WR_DATA1,   32'hbbbb_0001},
      '{adel_pkg::OFS_WR_DATA2,   32'hcccc_0002},
      '{adel_pkg::OFS_WR_DATA3,   32'hdddd_0003},
      '{adel_pkg::OFS_WR_ATTR,    32'h0000_0000},
      '{adel_pkg::OFS_STATUS,     32'h0000_0000},
      '{9'h1f0,                   32'h0000_0000}};
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    // every register reads its reset value
    chk({30'h0000_0000, irqRead, irqWrite}, 32'h0000_0000);
    foreach (rows[k]) csrRd(rows[k].ofs, 32'h0000_0000);
    csrIdle();
    // one violation each way, then the row table
    i_adel_viol_src.rdViol(RA, 8'ha5, 64'h1234_5678_9abc_def0, 1'b1);
    chk({28'h000_0000, rdRespValid, rdResp, irqRead}, {28'h000_0000, 1'b1, 2'h3, 1'b1});
    i_adel_viol_src.wrViol(WA, 8'h5a, 64'hfedc_ba98_7654_3210,
                           128'hdddd_0003_cccc_0002_bbbb_0001_aaaa_0000, 1'b1);
    chk({28'h000_0000, wrRespValid, wrResp, irqWrite}, {28'h000_0000, 1'b1, 2'h3, 1'b1});
    foreach (rows[k]) csrRd(rows[k].ofs, rows[k].expv);
    csrIdle();
    chk({30'h0000_0000, irqRead, irqWrite}, 32'h0000_0000);
    // logging off: still an error answer, nothing logged
    csrEnable = 1'b0;
    i_adel_viol_src.rdViol(RA, 8'h11, 64'h0000_0000_0000_0040, 1'b1);
    chk({28'h000_0000, rdRespValid, rdResp, irqRead}, {28'h000_0000, 1'b1, 2'h3, 1'b0});
    csrEnable = 1'b1;
    // read log overflow, clear, drain until valid drops
    for (int k = 1; k <= DEPTH + 1; k++) i_adel_viol_src.rdViol(RA, 8'h01, 64'(k), k == DEPTH + 1);
    csrRd(adel_pkg::OFS_STATUS, 32'h0000_000a);
    csrWr(adel_pkg::OFS_STATUS, 32'h0000_0008);
    csrRd(adel_pkg::OFS_STATUS, 32'h0000_0002);
    for (int k = 1; k <= DEPTH; k++) csrRd(adel_pkg::OFS_RD_ADDR_LO, 32'(k));
    csrRd(adel_pkg::OFS_RD_ATTR, 32'h0000_0000);
    csrIdle();
    // write log overflow, clear, drain through the last data word
    for (int k = 1; k <= DEPTH + 1; k++) begin
      i_adel_viol_src.wrViol(WA, 8'h02, 64'(k), 128'(k), k == DEPTH + 1);
    end
    csrRd(adel_pkg::OFS_STATUS, 32'h0000_0005);
    csrWr(adel_pkg::OFS_STATUS, 32'h0000_0004);
    csrRd(adel_pkg::OFS_STATUS, 32'h0000_0001);
    for (int k = 1; k <= DEPTH; k++) begin
      csrRd(adel_pkg::OFS_WR_DATA0, 32'(k));
      csrRd(adel_pkg::OFS_WR_DATA3, 32'h0000_0000);
    end
    csrRd(adel_pkg::OFS_WR_ATTR, 32'h0000_0000);
    csrIdle();
    chk({30'h0000_0000, irqRead, irqWrite}, 32'h0000_0000);
    // mid-run reset drops a full log, its overflow and its interrupt
    for (int k = 1; k <= DEPTH + 1; k++) i_adel_viol_src.rdViol(RA, 8'h03, 64'(k), k == DEPTH + 1);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk({30'h0000_0000, irqRead, irqWrite}, 32'h0000_0000);
    csrRd(adel_pkg::OFS_STATUS, 32'h0000_0000);
    csrRd(adel_pkg::OFS_RD_ATTR, 32'h0000_0000);
    csrIdle();
    results();
  end
endmodule

/* File: verilog/adel_logger.sv */
// Purpose: error log register bank of an axi decode error slave
// Assumes: violation strobes come from the error slave's channel logic
// Notes:   separate read and write log fifos, csr port of fixed latency
//
// Operation
// - read log meaningful only while interrupt set
// - attribute bits 12:11 burst type, 31:13 zero
// - attribute bits 10:7 hold burst length
// - attribute bits 6:4 hold burst size
// - attribute bits 3:1 hold protection value
// - bit 0 valid, clears with interrupt
// - master id at 0x104 and 0x194
// - read address low word at 0x108
// - write address low word at 0x198
// - write address high word at 0x19C
// - 0x1A0 data low; retires when 32-bit
// - 0x1A4 returns write data 63:32
// - 0x1A8 returns write data 95:64
// - 0x1AC data 127:96, read retires entry
// - violation: decode error; log push and interrupt when csrEnable and log not full
// - full fifo sets w1c overflow bit
// - interrupt holds while log holds entries
// - csr slave, read latency one cycle
`timescale 1ns/1ps
module adel_logger #(
  parameter int ID_W   = 8,   // master id width
  parameter int ADDR_W = 64,  // axi address width
  parameter int DATA_W = 128, // axi data width
  parameter int DEPTH  = 16   // entries per log
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              csrEnable,
  input  wire logic              rdViolValid,
  input  wire logic [1:0]        rdViolBurst,
  input  wire logic [3:0]        rdViolLen,
  input  wire logic [2:0]        rdViolSize,
  input  wire logic [2:0]        rdViolProt,
  input  wire logic [ID_W-1:0]   rdViolId,
  input  wire logic [ADDR_W-1:0] rdViolAddr,
  input  wire logic              wrViolValid,
  input  wire logic [1:0]        wrViolBurst,
  input  wire logic [3:0]        wrViolLen,
  input  wire logic [2:0]        wrViolSize,
  input  wire logic [2:0]        wrViolProt,
  input  wire logic [ID_W-1:0]   wrViolId,
  input  wire logic [ADDR_W-1:0] wrViolAddr,
  input  wire logic [DATA_W-1:0] wrViolData,
  input  wire logic [8:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  output logic [31:0]            readdata,
  output logic                   readdatavalid,
  output logic                   rdRespValid,
  output logic [1:0]             rdResp,
  output logic                   wrRespValid,
  output logic [1:0]             wrResp,
  output logic                   irqRead,
  output logic                   irqWrite
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1; // pointer width
  localparam int CNT_W = $clog2(DEPTH + 1);               // count width

  // refuse widths the datapath cannot serve
  if (ID_W < 1 || ID_W > 32 || ADDR_W < 8 || ADDR_W > 64 || DEPTH < 1 || DEPTH > 16 ||
      !(DATA_W == 32 || DATA_W == 64 || DATA_W == 128)) begin : gBadParam
    $error("adel_logger: unsupported parameter value");
  end

  // wrap-around pointer advance
  function automatic logic [PTR_W-1:0] nextPtr(input logic [PTR_W-1:0] p);
    nextPtr = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  // build an attribute word from the logged fields
  function automatic logic [31:0] packAttr(input logic [1:0] b, input logic [3:0] l,
                                           input logic [2:0] s, input logic [2:0] p,
                                           input logic v);
    packAttr = adel_pkg::RST_WORD;                          // reserved 31:13 stay zero
    packAttr[adel_pkg::AT_BURST_LSB +: 2] = b;              // burst type
    packAttr[adel_pkg::AT_LEN_LSB +: 4]   = l;              // burst length
    packAttr[adel_pkg::AT_SIZE_LSB +: 3]  = s;              // burst size
    packAttr[adel_pkg::AT_PROT_LSB +: 3]  = p;              // protection
    packAttr[adel_pkg::AT_VALID_BIT]      = v;              // entry valid
  endfunction

  // log storage, one fifo per direction
  logic [11:0]       rdAttrMem [DEPTH];  // burst, len, size, prot of read
  logic [ID_W-1:0]   rdIdMem   [DEPTH];  // read master ids
  logic [ADDR_W-1:0] rdAddrMem [DEPTH];  // read addresses
  logic [11:0]       wrAttrMem [DEPTH];  // attributes of write
  logic [ID_W-1:0]   wrIdMem   [DEPTH];  // write master ids
  logic [ADDR_W-1:0] wrAddrMem [DEPTH];  // write addresses
  logic [DATA_W-1:0] wrDataMem [DEPTH];  // write data

  logic [PTR_W-1:0] rdHead_r;            // oldest read entry
  logic [PTR_W-1:0] rdTail_r;            // next free read slot
  logic [CNT_W-1:0] rdCount_r;           // read entries held
  logic [PTR_W-1:0] wrHead_r;            // oldest write entry
  logic [PTR_W-1:0] wrTail_r;            // next free write slot
  logic [CNT_W-1:0] wrCount_r;           // write entries held
  logic             rdOvf_r;             // read overflow sticky
  logic             wrOvf_r;             // write overflow sticky

  logic rdFull;                          // read log full
  logic wrFull;                          // write log full
  logic rdPush;                          // read entry accepted
  logic wrPush;                          // write entry accepted
  logic rdPop;                           // read entry retired
  logic wrPop;                           // write entry retired
  logic rdNotEmpty;                      // read log holds an entry
  logic wrNotEmpty;                      // write log holds an entry
  logic [127:0]      wrHeadData;         // head write data, zero extended
  logic [63:0]       wrHeadAddr;         // head write address, zero extended
  logic [63:0]       rdHeadAddr;         // head read address, zero extended
  logic [11:0]       rdHeadAttr;         // head read attributes, packed
  logic [31:0]       rdMux;              // selected csr word

  // fifo status and push / pop decisions
  always_comb begin
    rdFull     = (rdCount_r == CNT_W'(DEPTH));
    wrFull     = (wrCount_r == CNT_W'(DEPTH));
    rdNotEmpty = (rdCount_r != '0);
    wrNotEmpty = (wrCount_r != '0);
    rdPush     = csrEnable && rdViolValid && !rdFull;
    wrPush     = csrEnable && wrViolValid && !wrFull;
    rdPop      = read && (address == adel_pkg::OFS_RD_ADDR_LO) && rdNotEmpty;
    wrPop      = read && wrNotEmpty &&
                 ((address == adel_pkg::OFS_WR_DATA3) ||
                  (DATA_W == 32 && address == adel_pkg::OFS_WR_DATA0));
  end

  // read log pointers and count
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdHead_r  <= '0;
      rdTail_r  <= '0;
      rdCount_r <= '0;
    end else begin
      if (rdPush) begin
        rdTail_r <= nextPtr(rdTail_r);
      end
      if (rdPop) begin
        rdHead_r <= nextPtr(rdHead_r);
      end
      if (rdPush && !rdPop) begin
        rdCount_r <= rdCount_r + CNT_W'(1);
      end else if (rdPop && !rdPush) begin
        rdCount_r <= rdCount_r - CNT_W'(1);
      end
    end
  end

  // write log pointers and count
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wrHead_r  <= '0;
      wrTail_r  <= '0;
      wrCount_r <= '0;
    end else begin
      if (wrPush) begin
        wrTail_r <= nextPtr(wrTail_r);
      end
      if (wrPop) begin
        wrHead_r <= nextPtr(wrHead_r);
      end
      if (wrPush && !wrPop) begin
        wrCount_r <= wrCount_r + CNT_W'(1);
      end else if (wrPop && !wrPush) begin
        wrCount_r <= wrCount_r - CNT_W'(1);
      end
    end
  end

  // log storage writes, no reset needed on the arrays
  always_ff @(posedge clk_sys) begin
    if (rdPush) begin
      rdAttrMem[rdTail_r] <= {rdViolBurst, rdViolLen, rdViolSize, rdViolProt};
      rdIdMem[rdTail_r]   <= rdViolId;
      rdAddrMem[rdTail_r] <= rdViolAddr;
    end
    if (wrPush) begin
      wrAttrMem[wrTail_r] <= {wrViolBurst, wrViolLen, wrViolSize, wrViolProt};
      wrIdMem[wrTail_r]   <= wrViolId;
      wrAddrMem[wrTail_r] <= wrViolAddr;
      wrDataMem[wrTail_r] <= wrViolData;
    end
  end

  // overflow stickies, a new overflow beats a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdOvf_r <= 1'b0;
      wrOvf_r <= 1'b0;
    end else begin
      if (csrEnable && rdViolValid && rdFull) begin
        rdOvf_r <= 1'b1;
      end else if (write && address == adel_pkg::OFS_STATUS &&
                   writedata[adel_pkg::ST_RD_OVF_BIT]) begin
        rdOvf_r <= 1'b0;
      end
      if (csrEnable && wrViolValid && wrFull) begin
        wrOvf_r <= 1'b1;
      end else if (write && address == adel_pkg::OFS_STATUS &&
                   writedata[adel_pkg::ST_WR_OVF_BIT]) begin
        wrOvf_r <= 1'b0;
      end
    end
  end

  // decode error answer to every violating cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdRespValid <= 1'b0;
      rdResp      <= adel_pkg::RESP_OKAY;
      wrRespValid <= 1'b0;
      wrResp      <= adel_pkg::RESP_OKAY;
    end else begin
      rdRespValid <= rdViolValid;
      rdResp      <= rdViolValid ? adel_pkg::RESP_DECERR : adel_pkg::RESP_OKAY;
      wrRespValid <= wrViolValid;
      wrResp      <= wrViolValid ? adel_pkg::RESP_DECERR : adel_pkg::RESP_OKAY;
    end
  end

  // interrupt levels follow the next fill state of each log
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irqRead  <= 1'b0;
      irqWrite <= 1'b0;
    end else begin
      irqRead  <= rdPush || (rdNotEmpty && !(rdPop && rdCount_r == CNT_W'(1)));
      irqWrite <= wrPush || (wrNotEmpty && !(wrPop && wrCount_r == CNT_W'(1)));
    end
  end

  // zero-extend head fields to full register width
  always_comb begin
    wrHeadData = 128'(wrDataMem[wrHead_r]);
    wrHeadAddr = 64'(wrAddrMem[wrHead_r]);
    rdHeadAddr = 64'(rdAddrMem[rdHead_r]);
    rdHeadAttr = rdAttrMem[rdHead_r];
  end

  // csr read selection; empty logs read as all zero
  always_comb begin
    rdMux = adel_pkg::RST_WORD;
    case (address)
      adel_pkg::OFS_STATUS: begin
        rdMux[adel_pkg::ST_RD_OVF_BIT]  = rdOvf_r;
        rdMux[adel_pkg::ST_WR_OVF_BIT]  = wrOvf_r;
        rdMux[adel_pkg::ST_RD_PEND_BIT] = rdNotEmpty;
        rdMux[adel_pkg::ST_WR_PEND_BIT] = wrNotEmpty;
      end
      adel_pkg::OFS_RD_ATTR: begin
        if (rdNotEmpty) begin
          rdMux = packAttr(rdHeadAttr[11:10], rdHeadAttr[9:6], rdHeadAttr[5:3],
                           rdHeadAttr[2:0], 1'b1);
        end
      end
      adel_pkg::OFS_RD_ID: begin
        if (rdNotEmpty) begin
          rdMux = 32'(rdIdMem[rdHead_r]);
        end
      end
      adel_pkg::OFS_RD_ADDR_LO: begin
        if (rdNotEmpty) begin
          rdMux = rdHeadAddr[31:0];
        end
      end
      adel_pkg::OFS_WR_ATTR: begin
        if (wrNotEmpty) begin
          rdMux = packAttr(wrAttrMem[wrHead_r][11:10], wrAttrMem[wrHead_r][9:6],
                           wrAttrMem[wrHead_r][5:3], wrAttrMem[wrHead_r][2:0], 1'b1);
        end
      end
      adel_pkg::OFS_WR_ID: begin
        if (wrNotEmpty) begin
          rdMux = 32'(wrIdMem[wrHead_r]);
        end
      end
      adel_pkg::OFS_WR_ADDR_LO: rdMux = wrNotEmpty ? wrHeadAddr[31:0] : '0;
      adel_pkg::OFS_WR_ADDR_HI: rdMux = wrNotEmpty ? wrHeadAddr[63:32] : '0;
      adel_pkg::OFS_WR_DATA0:   rdMux = wrNotEmpty ? wrHeadData[31:0] : '0;
      adel_pkg::OFS_WR_DATA1:   rdMux = wrNotEmpty ? wrHeadData[63:32] : '0;
      adel_pkg::OFS_WR_DATA2:   rdMux = wrNotEmpty ? wrHeadData[95:64] : '0;
      adel_pkg::OFS_WR_DATA3:   rdMux = wrNotEmpty ? wrHeadData[127:96] : '0;
      default:                  rdMux = adel_pkg::RST_WORD;                    // unmapped
    endcase
  end

  // registered read answer, one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      readdata      <= adel_pkg::RST_WORD;
      readdatavalid <= 1'b0;
    end else begin
      readdatavalid <= read;
      if (read) begin
        readdata <= rdMux;
      end
    end
  end

  // checks on the log behaviour
  AST_RD_LATENCY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    read |=> readdatavalid ##1 (readdatavalid == $past(read)))
    else $error("read answer not one cycle after request");
  AST_RD_ATTR_WORD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (read && address == adel_pkg::OFS_RD_ATTR && rdNotEmpty) |=>
      (readdata == {19'h0_0000, $past(rdHeadAttr), 1'b1}))
    else $error("read attribute word fields wrong");
  AST_VALID_EMPTY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (read && address == adel_pkg::OFS_WR_ATTR && !wrNotEmpty) |=> readdata == 32'h0000_0000)
    else $error("write log valid bit set with empty log");
  AST_RD_PUSH: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rdPush && !rdPop) |=> rdCount_r == $past(rdCount_r) + CNT_W'(1) ##0 irqRead)
    else $error("accepted read violation not logged");
  AST_RD_RETIRE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (read && address == adel_pkg::OFS_RD_ADDR_LO && rdNotEmpty && !rdPush) |=>
      rdCount_r == $past(rdCount_r) - CNT_W'(1))
    else $error("read log entry not retired by address read");
  AST_WR_RETIRE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (read && address == adel_pkg::OFS_WR_DATA3 && wrNotEmpty && !wrPush) |=>
      wrCount_r == $past(wrCount_r) - CNT_W'(1))
    else $error("write log entry not retired by last data read");
  AST_OVF_SET: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (csrEnable && wrViolValid && wrFull) |=> wrOvf_r ##1 (wrOvf_r || $past(write)))
    else $error("write overflow not flagged");
  AST_IRQ_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rdCount_r > CNT_W'(1)) |=> irqRead)
    else $error("read interrupt dropped with entries left");
  AST_DECERR: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wrViolValid |=> (wrRespValid && wrResp == adel_pkg::RESP_DECERR))
    else $error("write violation not answered with decode error");

  COV_RD_LOG_READ: cover property (@(posedge clk_sys) disable iff (sys_rst)
    rdPush ##[1:4] rdPop);
  COV_WR_FULL_OVF: cover property (@(posedge clk_sys) disable iff (sys_rst)
    wrFull && wrViolValid && csrEnable);
  COV_PUSH_POP: cover property (@(posedge clk_sys) disable iff (sys_rst)
    rdPush && rdPop);
endmodule

/* File: verilog/adel_pkg.sv */
// Purpose: constants shared by the decode error logger register bank
// Assumes: byte offsets on the csr port, one 32-bit word per register
// Notes:   all offsets, field positions and reset values live here
package adel_pkg;
  // csr byte offsets
  localparam logic [8:0]  OFS_STATUS      = 9'h000; // overflow and pending status
  localparam logic [8:0]  OFS_RD_ATTR     = 9'h100; // read log attributes
  localparam logic [8:0]  OFS_RD_ID       = 9'h104; // read log master id
  localparam logic [8:0]  OFS_RD_ADDR_LO  = 9'h108; // read log address low
  localparam logic [8:0]  OFS_WR_ATTR     = 9'h190; // write log attributes
  localparam logic [8:0]  OFS_WR_ID       = 9'h194; // write log master id
  localparam logic [8:0]  OFS_WR_ADDR_LO  = 9'h198; // write log address low
  localparam logic [8:0]  OFS_WR_ADDR_HI  = 9'h19C; // write log address high
  localparam logic [8:0]  OFS_WR_DATA0    = 9'h1A0; // write data 31:0
  localparam logic [8:0]  OFS_WR_DATA1    = 9'h1A4; // write data 63:32
  localparam logic [8:0]  OFS_WR_DATA2    = 9'h1A8; // write data 95:64
  localparam logic [8:0]  OFS_WR_DATA3    = 9'h1AC; // write data 127:96
  // status word bit positions
  localparam int          ST_RD_OVF_BIT   = 3;      // read overflow, w1c
  localparam int          ST_WR_OVF_BIT   = 2;      // write overflow, w1c
  localparam int          ST_RD_PEND_BIT  = 1;      // read log not empty, ro
  localparam int          ST_WR_PEND_BIT  = 0;      // write log not empty, ro
  // attribute word field positions
  localparam int          AT_BURST_LSB    = 11;     // burst type 12:11
  localparam int          AT_LEN_LSB      = 7;      // burst length 10:7
  localparam int          AT_SIZE_LSB     = 4;      // burst size 6:4
  localparam int          AT_PROT_LSB     = 1;      // protection 3:1
  localparam int          AT_VALID_BIT    = 0;      // entry valid
  // reset values and response code
  localparam logic [31:0] RST_WORD        = 32'h0000_0000; // every register resets to 0
  localparam logic [1:0]  RESP_DECERR     = 2'h3;   // axi decode error
  localparam logic [1:0]  RESP_OKAY       = 2'h0;   // idle response value
  localparam int          CSR_RD_LATENCY  = 1;      // fixed read latency in cycles
endpackage
